// [rtl/timer_one_pkg.sv]
package timer_one_pkg;

   // Register offsets on the plain register port
   localparam logic [7:0] FLAG_REG_OFFSET    = 8'h0c;
   localparam logic [7:0] ENABLE_REG_OFFSET  = 8'h8c;
   localparam logic [7:0] COUNT_LOW_OFFSET   = 8'h0e;
   localparam logic [7:0] COUNT_HIGH_OFFSET  = 8'h0f;
   localparam logic [7:0] CONTROL_OFFSET     = 8'h10;

   // Field positions
   localparam int GATE_BIT      = 0;
   localparam int SOURCE_BIT    = 1;
   localparam int SYNC_DIS_BIT  = 2;
   localparam int OSC_EN_BIT    = 3;
   localparam int DIVIDER_LSB   = 4;
   localparam int DIVIDER_MSB   = 5;
   localparam int OVERFLOW_BIT  = 0;

   // Reset values
   localparam logic [7:0] CONTROL_RESET  = 8'h00;
   localparam logic       FLAG_RESET     = 1'b0;
   localparam logic       ENABLE_RESET   = 1'b0;

   // Count limits
   localparam logic [15:0] COUNT_MAX     = 16'hffff;
   localparam logic [15:0] COUNT_ZERO    = 16'h0000;

   // Instruction clock is one quarter of mclk
   localparam logic [1:0]  PHASE_LAST    = 2'h3;

   // Control register fields, bit 5 down to bit 0
   typedef struct packed
   {
      logic [1:0] divider;
      logic       osc_enable;
      logic       sync_disable;
      logic       source;
      logic       gate;
   } control_type;

   // One register port request
   typedef struct packed
   {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } bus_req_type;

   typedef enum logic [3:0]
   {
      MODE_STOPPED = 4'b0001,
      MODE_TIMER   = 4'b0010,
      MODE_SYNC    = 4'b0100,
      MODE_ASYNC   = 4'b1000
   } mode_type;

endpackage

// [rtl/input_divider.sv]
`timescale 1ns/1ps

// Divides a stream of one-cycle ticks by 1, 2, 4 or 8
module input_divider
(
   // Clock and reset
   input  wire logic       mclk,
   input  wire logic       rstn,
   // Control
   input  wire logic       clear,
   input  wire logic [1:0] select,
   // Ticks in and out
   input  wire logic       tick_in,
   output logic            tick_out
);

   logic [2:0] stage_reg;
   logic       out_reg;

   function automatic logic [2:0] tap_mask(input logic [1:0] sel);
      logic [2:0] m;
      m = 3'h0;
      unique case (sel)
         2'h0: m = 3'h0;
         2'h1: m = 3'h1;
         2'h2: m = 3'h3;
         2'h3: m = 3'h7;
      endcase
      return m;
   endfunction

   // Ripple stages modelled as one counter advanced by the source edge
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
         stage_reg <= 3'h0;
      else if (clear)
         stage_reg <= 3'h0;
      else if (tick_in)
         stage_reg <= stage_reg + 3'h1;
   end

   // Output fires when every selected stage wraps
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
         out_reg <= 1'b0;
      else
         out_reg <= tick_in && !clear
                    && ((stage_reg & tap_mask(select)) == tap_mask(select));
   end

   assign tick_out = out_reg;

endmodule

// [rtl/timer_one.sv]
`timescale 1ns/1ps

module timer_one
(
   // Clock and power-on reset
   input  wire logic       mclk,
   input  wire logic       rstn,
   // Register port
   input  wire logic [7:0] addr,
   input  wire logic [7:0] wdata,
   input  wire logic       wr_strobe,
   input  wire logic       rd_strobe,
   output logic      [7:0] rdata,
   // Count inputs and system status
   input  wire logic       external_count_pin,
   input  wire logic       crystal_input_pin,
   input  wire logic       sleep_mode,
   input  wire logic       special_event_trigger,
   // Status towards the rest of the chip
   output logic            overflow_irq,
   output logic            wake_request,
   output logic            crystal_osc_run,
   output logic            osc_pins_forced_input,
   output logic            capture_time_base_ok
);

   timer_one_pkg::bus_req_type req;
   timer_one_pkg::control_type ctrl_reg;
   timer_one_pkg::mode_type    mode_reg;
   timer_one_pkg::mode_type    mode_next;

   logic [15:0] count_reg;
   logic        flag_reg;
   logic        enable_reg;
   logic [7:0]  rdata_reg;
   logic [1:0]  phase_reg;
   logic        pin_prev_reg;
   logic        osc_prev_reg;
   logic        armed_reg;
   logic        sync_first_reg;
   logic        sync_second_reg;
   logic        irq_reg;
   logic        wake_reg;
   logic        osc_run_reg;
   logic        forced_reg;
   logic        time_base_reg;

   logic        selected_pin;
   logic        pin_rise;
   logic        pin_fall;
   logic        instr_tick;
   logic        divider_in;
   logic        divider_out;
   logic        count_write;
   logic        write_low;
   logic        write_high;
   logic        increment;
   logic        overflow;

   assign req.addr  = addr;
   assign req.wdata = wdata;
   assign req.wr    = wr_strobe;
   assign req.rd    = rd_strobe;

   function automatic logic hit_write(input timer_one_pkg::bus_req_type r,
                                      input logic [7:0] offset);
      return r.wr && (r.addr == offset);
   endfunction

   assign write_low   = hit_write(req, timer_one_pkg::COUNT_LOW_OFFSET);
   assign write_high  = hit_write(req, timer_one_pkg::COUNT_HIGH_OFFSET);
   assign count_write = write_low || write_high;

   // Edge source for counter mode
   assign selected_pin = ctrl_reg.osc_enable ? crystal_input_pin
                                             : external_count_pin;
   assign pin_rise = selected_pin && !pin_prev_reg;
   assign pin_fall = !selected_pin && pin_prev_reg;

   // Internal instruction clock stops with the core in sleep
   assign instr_tick = (phase_reg == timer_one_pkg::PHASE_LAST) && !sleep_mode;

   // Mode decode
   always_comb
   begin
      mode_next = timer_one_pkg::MODE_STOPPED;
      if (!ctrl_reg.gate)
         mode_next = timer_one_pkg::MODE_STOPPED;
      else if (!ctrl_reg.source)
         mode_next = timer_one_pkg::MODE_TIMER;
      else if (ctrl_reg.sync_disable)
         mode_next = timer_one_pkg::MODE_ASYNC;
      else
         mode_next = timer_one_pkg::MODE_SYNC;
   end

   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
         mode_reg <= timer_one_pkg::MODE_STOPPED;
      else
         mode_reg <= mode_next;
   end

   // Instruction phase counter
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
         phase_reg <= 2'h0;
      else
         phase_reg <= phase_reg + 2'h1;
   end

   // Pin history for edge detection; inputs are already synchronous
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
         pin_prev_reg <= 1'b0;
      else
         pin_prev_reg <= selected_pin;
   end

   // Pin source history; after a pin switch the old pin's level means nothing
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
         osc_prev_reg <= 1'b0;
      else
         osc_prev_reg <= ctrl_reg.osc_enable;
   end

   // A falling edge must be seen after enabling before rising edges count
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
         armed_reg <= 1'b0;
      else if (!ctrl_reg.gate || !ctrl_reg.source
               || (ctrl_reg.osc_enable != osc_prev_reg))
         armed_reg <= 1'b0;
      else if (pin_fall)
         armed_reg <= 1'b1;
   end

   // Divider input: external edges are not gated by sleep
   always_comb
   begin
      divider_in = 1'b0;
      unique case (mode_reg)
         timer_one_pkg::MODE_STOPPED: divider_in = 1'b0;
         timer_one_pkg::MODE_TIMER:   divider_in = instr_tick;
         timer_one_pkg::MODE_SYNC:    divider_in = pin_rise && armed_reg;
         timer_one_pkg::MODE_ASYNC:   divider_in = pin_rise && armed_reg;
      endcase
   end

   input_divider divider
   (
      .mclk     (mclk),
      .rstn     (rstn),
      .clear    (count_write),
      .select   (ctrl_reg.divider),
      .tick_in  (divider_in),
      .tick_out (divider_out)
   );

   // Synchroniser after the divider; held at zero during sleep
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
      begin
         sync_first_reg  <= 1'b0;
         sync_second_reg <= 1'b0;
      end
      else if (sleep_mode)
      begin
         sync_first_reg  <= 1'b0;
         sync_second_reg <= 1'b0;
      end
      else
      begin
         sync_first_reg  <= divider_out;
         sync_second_reg <= sync_first_reg;
      end
   end

   // Increment source per mode
   always_comb
   begin
      increment = 1'b0;
      unique case (mode_reg)
         timer_one_pkg::MODE_STOPPED: increment = 1'b0;
         timer_one_pkg::MODE_TIMER:   increment = divider_out;
         timer_one_pkg::MODE_SYNC:    increment = sync_second_reg;
         timer_one_pkg::MODE_ASYNC:   increment = divider_out;
      endcase
   end

   assign overflow = increment && !count_write && !special_event_trigger
                     && (count_reg == timer_one_pkg::COUNT_MAX);

   // Count has no reset at all; only the trigger or software defines it.
   // A write that meets an increment simply wins over it.
   always_ff @(posedge mclk)
   begin
      if (count_write)
      begin
         if (write_low)
            count_reg[7:0] <= req.wdata;
         if (write_high)
            count_reg[15:8] <= req.wdata;
      end
      else if (special_event_trigger)
         count_reg <= timer_one_pkg::COUNT_ZERO;
      else if (increment)
         count_reg <= count_reg + 16'h0001;
   end

   // Control register, cleared only by the power-on reset
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
         ctrl_reg <= timer_one_pkg::CONTROL_RESET[5:0];
      else if (hit_write(req, timer_one_pkg::CONTROL_OFFSET))
         ctrl_reg <= req.wdata[timer_one_pkg::DIVIDER_MSB:0];
   end

   // Sticky overflow flag; a new overflow beats a software clear
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
         flag_reg <= timer_one_pkg::FLAG_RESET;
      else if (overflow)
         flag_reg <= 1'b1;
      else if (hit_write(req, timer_one_pkg::FLAG_REG_OFFSET))
         flag_reg <= req.wdata[timer_one_pkg::OVERFLOW_BIT];
   end

   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
         enable_reg <= timer_one_pkg::ENABLE_RESET;
      else if (hit_write(req, timer_one_pkg::ENABLE_REG_OFFSET))
         enable_reg <= req.wdata[timer_one_pkg::OVERFLOW_BIT];
   end

   // Read data from registered state, so a byte never tears mid-cycle
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
         rdata_reg <= 8'h00;
      else if (req.rd)
      begin
         unique case (req.addr)
            timer_one_pkg::COUNT_LOW_OFFSET:
               rdata_reg <= count_reg[7:0];
            timer_one_pkg::COUNT_HIGH_OFFSET:
               rdata_reg <= count_reg[15:8];
            timer_one_pkg::CONTROL_OFFSET:
               rdata_reg <= {2'h0, ctrl_reg};
            timer_one_pkg::FLAG_REG_OFFSET:
               rdata_reg <= {7'h00, flag_reg};
            timer_one_pkg::ENABLE_REG_OFFSET:
               rdata_reg <= {7'h00, enable_reg};
            default:
               rdata_reg <= 8'h00;
         endcase
      end
      else
         rdata_reg <= 8'h00;
   end

   // Interrupt request follows the flag, gated by the enable, one cycle later
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
         irq_reg <= 1'b0;
      else
         irq_reg <= flag_reg && enable_reg;
   end

   // Wake-up is only asked for while the processor sleeps
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
         wake_reg <= 1'b0;
      else
         wake_reg <= flag_reg && enable_reg && sleep_mode;
   end

   // Oscillator runs while enabled, sleep or not
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
         osc_run_reg <= 1'b0;
      else
         osc_run_reg <= ctrl_reg.osc_enable;
   end

   // Port logic forces both crystal pins to inputs reading zero
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
         forced_reg <= 1'b0;
      else
         forced_reg <= ctrl_reg.osc_enable;
   end

   // Capture and compare must not lean on the unsynchronised count
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
         time_base_reg <= 1'b0;
      else
         time_base_reg <= mode_reg != timer_one_pkg::MODE_ASYNC;
   end

   assign rdata                 = rdata_reg;
   assign overflow_irq          = irq_reg;
   assign wake_request          = wake_reg;
   assign crystal_osc_run       = osc_run_reg;
   assign osc_pins_forced_input = forced_reg;
   assign capture_time_base_ok  = time_base_reg;

endmodule

// [tb/ext_clock_src.sv]
`timescale 1ns/1ps

// Behavioural external clock or crystal: toggles every half cycles while run is high
module ext_clock_src
(
   // Clock
   input  wire logic       mclk,
   // Control
   input  wire logic       run,
   input  wire logic [7:0] half,
   // Pin
   output logic            pin
);
   int cnt = 0;

   initial pin = 1'b0;

   // Stands low between bursts, so a burst opens with a rising edge
   always @(posedge mclk)
   begin
      if (!run)
      begin
         cnt <= 0;
         pin <= 1'b0;
      end
      else if (cnt >= half - 1)
      begin
         cnt <= 0;
         pin <= !pin;
      end
      else
         cnt <= cnt + 1;
   end
endmodule

// [tb/timer_one_checker.sv]
`timescale 1ns/1ps

module timer_one_checker
(
   // Clock and reset
   input wire logic       mclk,
   input wire logic       rstn,
   // Register port
   input wire logic [7:0] addr,
   input wire logic [7:0] wdata,
   input wire logic       wr_strobe,
   input wire logic       rd_strobe,
   input wire logic [7:0] rdata,
   // Status
   input wire logic       sleep_mode,
   input wire logic       overflow_irq,
   input wire logic       wake_request,
   input wire logic       crystal_osc_run,
   input wire logic       osc_pins_forced_input,
   input wire logic       capture_time_base_ok
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rstn);

   property p_ctrl_unimpl;
      rd_strobe && addr == timer_one_pkg::CONTROL_OFFSET |=> rdata[7:6] == 2'b00;
   endproperty
   a_ctrl_unimpl: assert property (p_ctrl_unimpl)
      else $error("control upper bits not zero");

   property p_irq_mask;
      wr_strobe && addr == timer_one_pkg::ENABLE_REG_OFFSET && !wdata[0] |-> ##2 !overflow_irq;
   endproperty
   a_irq_mask: assert property (p_irq_mask)
      else $error("irq not masked");

   // Only software writes may drop the request
   property p_flag_sticky;
      overflow_irq && !$past(wr_strobe) |=> overflow_irq;
   endproperty
   a_flag_sticky: assert property (p_flag_sticky)
      else $error("overflow request dropped");

   property p_wake;
      wake_request |-> overflow_irq && $past(sleep_mode);
   endproperty
   a_wake: assert property (p_wake)
      else $error("wake without request or sleep");

   property p_osc_run;
      wr_strobe && addr == timer_one_pkg::CONTROL_OFFSET |-> ##2
         crystal_osc_run == $past(wdata[3], 2);
   endproperty
   a_osc_run: assert property (p_osc_run)
      else $error("oscillator run mismatch");

   property p_pins_forced;
      wr_strobe && addr == timer_one_pkg::CONTROL_OFFSET |-> ##2
         osc_pins_forced_input == $past(wdata[3], 2);
   endproperty
   a_pins_forced: assert property (p_pins_forced)
      else $error("pin forcing mismatch");

   property p_time_base;
      wr_strobe && addr == timer_one_pkg::CONTROL_OFFSET && wdata[1:0] == 2'b11 |-> ##3
         capture_time_base_ok == !$past(wdata[2], 3);
   endproperty
   a_time_base: assert property (p_time_base)
      else $error("time base offer wrong");

   property p_rdata_idle;
      !$past(rd_strobe) |-> rdata == 8'h00;
   endproperty
   a_rdata_idle: assert property (p_rdata_idle)
      else $error("read data outside read cycle");
endmodule

bind timer_one timer_one_checker i_chk (.mclk, .rstn, .addr, .wdata, .wr_strobe, .rd_strobe,
   .rdata, .sleep_mode, .overflow_irq, .wake_request, .crystal_osc_run,
   .osc_pins_forced_input, .capture_time_base_ok);

// [tb/tb.sv]
`timescale 1ns/1ps

`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin err_total++; \
   $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp); end end

module tb;
   localparam logic [7:0] CTL = timer_one_pkg::CONTROL_OFFSET;
   localparam logic [7:0] LO  = timer_one_pkg::COUNT_LOW_OFFSET;
   localparam logic [7:0] HI  = timer_one_pkg::COUNT_HIGH_OFFSET;
   localparam logic [7:0] FLG = timer_one_pkg::FLAG_REG_OFFSET;
   localparam logic [7:0] ENA = timer_one_pkg::ENABLE_REG_OFFSET;

   logic       mclk                  = 1'b0;
   logic       rstn                  = 1'b0;
   logic [7:0] addr                  = 8'h00;
   logic [7:0] wdata                 = 8'h00;
   logic       wr_strobe             = 1'b0;
   logic       rd_strobe             = 1'b0;
   logic       sleep_mode            = 1'b0;
   logic       special_event_trigger = 1'b0;
   logic       go                    = 1'b0;
   logic [7:0] rdata;
   logic       external_count_pin;
   logic       crystal_input_pin;
   logic       overflow_irq;
   logic       wake_request;
   logic       crystal_osc_run;
   logic       osc_pins_forced_input;
   logic       capture_time_base_ok;
   logic [7:0] rv;
   logic [7:0] held;
   int         err_total   = 0;
   int         comparisons = 0;
   int         cycles      = 0;
   // Counter mode cases: control, sleep, expected low byte
   logic [7:0] cfg  [4] = '{8'h03, 8'h0b, 8'h07, 8'h03};
   logic       slp  [4] = '{1'b0, 1'b0, 1'b1, 1'b1};
   logic [7:0] want [4] = '{8'h04, 8'h09, 8'h04, 8'h00};

   always #10 mclk = ~mclk;

   timer_one i_dut (.mclk, .rstn, .addr, .wdata, .wr_strobe, .rd_strobe, .rdata,
      .external_count_pin, .crystal_input_pin, .sleep_mode, .special_event_trigger,
      .overflow_irq, .wake_request, .crystal_osc_run, .osc_pins_forced_input,
      .capture_time_base_ok);

   // Count pin at half the crystal rate, so a wrong pin choice shows in the count
   ext_clock_src i_ext (.mclk, .run(go), .half(8'h06), .pin(external_count_pin));
   ext_clock_src i_xtal (.mclk, .run(go), .half(8'h03), .pin(crystal_input_pin));

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk);
      addr      <= a;
      wdata     <= d;
      wr_strobe <= 1'b1;
      @(posedge mclk);
      wr_strobe <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge mclk);
      addr      <= a;
      rd_strobe <= 1'b1;
      @(posedge mclk);
      rd_strobe <= 1'b0;
      // Read data stand through the next cycle; take them at its closing edge
      @(posedge mclk);
      d = rdata;
   endtask

   task automatic tally_and_finish();
      $display("mismatches %0d comparisons %0d", err_total, comparisons);
      if (err_total == 0 && comparisons > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   always @(posedge mclk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         err_total++;
         tally_and_finish();
      end
   end

   initial
   begin
      repeat (3) @(posedge mclk);
      rstn <= 1'b1;
      rd(CTL, rv);
      `CHK(rv, 8'h00)
      rd(FLG, rv);
      `CHK(rv, 8'h00)
      wr(CTL, 8'hff);
      rd(CTL, rv);
      `CHK(rv, 8'h3f)
      rd(8'h55, rv);
      `CHK(rv, 8'h00)
      wr(CTL, 8'h00);
      // Timer mode: 256 cycles give 64 instruction ticks before division
      for (int d = 0; d < 4; d++)
      begin
         wr(LO, 8'h00);
         wr(HI, 8'h00);
         wr(CTL, {2'b00, 2'(d), 4'h1});
         repeat (256) @(posedge mclk);
         wr(CTL, 8'h00);
         rd(LO, held);
         `CHK(held >= (64 >> d) - 1 && held <= (64 >> d) + 1, 1'b1)
         repeat (20) @(posedge mclk);
         rd(LO, rv);
         `CHK(rv, held)
      end
      // Counter modes: the first rising edge of each burst must not count
      for (int i = 0; i < 4; i++)
      begin
         wr(LO, 8'h00);
         wr(HI, 8'h00);
         wr(CTL, cfg[i]);
         sleep_mode <= slp[i];
         repeat (8) @(posedge mclk);
         go <= 1'b1;
         repeat (60) @(posedge mclk);
         go <= 1'b0;
         repeat (10) @(posedge mclk);
         sleep_mode <= 1'b0;
         wr(CTL, 8'h00);
         rd(LO, rv);
         `CHK(rv, want[i])
      end
      wr(LO, 8'h80);
      wr(HI, 8'h12);
      @(posedge mclk);
      special_event_trigger <= 1'b1;
      @(posedge mclk);
      special_event_trigger <= 1'b0;
      rd(LO, rv);
      `CHK(rv, 8'h00)
      rd(HI, rv);
      `CHK(rv, 8'h00)
      @(posedge mclk);
      addr                  <= LO;
      wdata                 <= 8'h33;
      wr_strobe             <= 1'b1;
      special_event_trigger <= 1'b1;
      @(posedge mclk);
      wr_strobe             <= 1'b0;
      special_event_trigger <= 1'b0;
      rd(LO, rv);
      `CHK(rv, 8'h33)
      // Overflow: 40 cycles from fffc wraps well past zero
      wr(FLG, 8'h00);
      wr(ENA, 8'h01);
      wr(HI, 8'hff);
      wr(LO, 8'hfc);
      wr(CTL, 8'h01);
      repeat (40) @(posedge mclk);
      wr(CTL, 8'h00);
      repeat (2) @(posedge mclk);
      #1;
      `CHK(overflow_irq, 1'b1)
      rd(FLG, rv);
      `CHK(rv, 8'h01)
      rd(HI, rv);
      `CHK(rv, 8'h00)
      rd(HI, held);
      `CHK(held, rv)
      sleep_mode <= 1'b1;
      repeat (3) @(posedge mclk);
      #1;
      `CHK(wake_request, 1'b1)
      @(posedge mclk);
      sleep_mode <= 1'b0;
      wr(ENA, 8'h00);
      repeat (3) @(posedge mclk);
      #1;
      `CHK(overflow_irq, 1'b0)
      wr(ENA, 8'h01);
      repeat (3) @(posedge mclk);
      #1;
      `CHK(overflow_irq, 1'b1)
      wr(FLG, 8'h00);
      repeat (3) @(posedge mclk);
      #1;
      `CHK(overflow_irq, 1'b0)
      // Power-on reset clears control but leaves the count alone
      wr(HI, 8'h5a);
      wr(CTL, 8'h30);
      @(posedge mclk);
      rstn <= 1'b0;
      repeat (2) @(posedge mclk);
      rstn <= 1'b1;
      rd(HI, rv);
      `CHK(rv, 8'h5a)
      rd(CTL, rv);
      `CHK(rv, 8'h00)
      tally_and_finish();
   end
endmodule
